// ### hdl/prio_chain_params.svh
// Offsets, reset values and fixed level positions of the priority chain.
// Included by the priority_interrupt_chain module; definitions only.
`ifndef PRIO_CHAIN_PARAMS_SVH
`define PRIO_CHAIN_PARAMS_SVH

// Register byte offsets on the Wishbone slave
`define PCH_OFS_STATUS 8'h00
`define PCH_OFS_MASK 8'h04
`define PCH_OFS_ACTIVE 8'h08
`define PCH_OFS_PROGREQ 8'h0c
`define PCH_OFS_SERVICE 8'h10
`define PCH_OFS_FLAGS 8'h14

// Reset values
`define PCH_MASK_RESET 32'h00000000
`define PCH_STATUS_RESET 32'h00000000
`define PCH_FLAGS_RESET 4'h0

// Level counts
`define PCH_BASE_LEVELS 8
`define PCH_LEVEL_STEP 8
`define PCH_MAX_LEVELS 32
`define PCH_INTERNAL_LEVELS 4
`define PCH_NO_LEVEL 6'h20

// Chain positions of the internal sources, 0 is level one
`define PCH_IDX_POWER 0
`define PCH_IDX_PROGRAM 1
`define PCH_IDX_TELETYPE 2
`define PCH_IDX_BUTTON 3

// Field positions of the indicator word
`define PCH_FLAG_ZERO 0
`define PCH_FLAG_POSITIVE 1
`define PCH_FLAG_NEGATIVE 2
`define PCH_FLAG_OVERFLOW 3

// Service register fields
`define PCH_SVC_LEVEL_LSB 0
`define PCH_SVC_DEPTH_LSB 8

`endif

// ### hdl/prio_chain_pkg.sv
// Types shared by the priority chain design.
// Constants live in prio_chain_params.svh.
package prio_chain_pkg;

   // The four result indicators kept by the arithmetic unit
   typedef struct packed {
      logic overflow_result_flag;
      logic negative_result_flag;
      logic positive_result_flag;
      logic zero_result_flag;
   } indicator_s;

   // Register selected by a bus address
   typedef enum logic [2:0] {
      SEL_STATUS = 3'h0,
      SEL_MASK = 3'h1,
      SEL_ACTIVE = 3'h2,
      SEL_PROGREQ = 3'h3,
      SEL_SERVICE = 3'h4,
      SEL_FLAGS = 3'h5,
      SEL_NONE = 3'h7
   } reg_sel_e;

endpackage

// ### hdl/save_stack.sv
// Last-in first-out store of program counter and indicators per nesting step.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps

module save_stack #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 20
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [WIDTH-1:0] push_data_in,
   output logic [WIDTH-1:0] top_data_out,
   output logic [$clog2(DEPTH+1)-1:0] depth_out
);

   localparam int PW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] ptr;
   } stack_s;

   stack_s r;
   stack_s next_r;

   if (DEPTH < 1) begin : g_bad_depth
      $error("save_stack needs a depth of at least one");
   end

   always_comb begin
      next_r = r;
      if (push_in && pop_in && r.ptr != '0) begin
         // Return and entry in one cycle replace the top
         next_r.mem[r.ptr - PW'(1)] = push_data_in;
      end else if (pop_in && r.ptr != '0) begin
         next_r.ptr = r.ptr - PW'(1);
      end else if (push_in && r.ptr != PW'(DEPTH)) begin
         next_r.mem[r.ptr] = push_data_in;
         next_r.ptr = r.ptr + PW'(1);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         r <= '0;
      end else if (clk_en_in) begin
         r <= next_r;
      end
   end

   assign top_data_out = (r.ptr == '0) ? '0 : r.mem[r.ptr - PW'(1)];
   assign depth_out = r.ptr;

endmodule

// ### hdl/priority_interrupt_chain.sv
// Expandable priority interrupt chain with hardware save and restore of
// program counter and result indicators, registers on a classic Wishbone slave.
// Assumes one processor clock, a synchronous reset and a processor that
// acknowledges entry and signals return by one-cycle pulses on this clock.
//
// Operation
// RQ1: Eight priority levels in one chain by default.
// RQ2: Levels extend in steps of eight, at most thirty-two, one chain.
// RQ3: Four top levels come from internal sources; rest are customer inputs.
// RQ4: Power fail level 1, program 2, teletype 3, panel button 4.
// RQ5: Service routines nest; depth bounded only by the level count.
// RQ6: Entry saves program counter and indicators; return restores both.
// RQ7: A request preempts only service at strictly lower priority.
// RQ8: Arithmetic updates zero, positive, negative and overflow indicators.
// RQ9: Power failure saves counter and indicators, then interrupts on level one; here power is a maskable level 1 request, saved at entry like every level.
// RQ10: Level one ranks highest; lowest-numbered pending level wins.
// RQ11: A blocked request stays pending until higher service completes.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "prio_chain_params.svh"

module priority_interrupt_chain #(
   parameter int NUM_LEVELS = `PCH_BASE_LEVELS,
   parameter int PC_WIDTH = 16
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // Request pins
   input wire logic power_fail_in,
   input wire logic teletype_req_in,
   input wire logic panel_button_in,
   input wire logic [NUM_LEVELS-5:0] customer_req_in,
   // Arithmetic unit indicators
   input wire logic alu_update_in,
   input wire logic zero_result_flag_in,
   input wire logic positive_result_flag_in,
   input wire logic negative_result_flag_in,
   input wire logic overflow_result_flag_in,
   output logic zero_result_flag_out,
   output logic positive_result_flag_out,
   output logic negative_result_flag_out,
   output logic overflow_result_flag_out,
   // Processor entry and return
   input wire logic [PC_WIDTH-1:0] pc_in,
   input wire logic entry_ack_in,
   input wire logic service_done_in,
   output logic entry_req_out,
   output logic [5:0] entry_level_out,
   output logic restore_valid_out,
   output logic [PC_WIDTH-1:0] restore_pc_out,
   output logic irq_out
);

   localparam int N = NUM_LEVELS;
   localparam int SW = PC_WIDTH + 4;
   localparam int DW = $clog2(NUM_LEVELS + 1);

   if (NUM_LEVELS < `PCH_BASE_LEVELS || NUM_LEVELS > `PCH_MAX_LEVELS ||
       NUM_LEVELS % `PCH_LEVEL_STEP != 0) begin : g_bad_levels  // [RQ2]
      $error("NUM_LEVELS must be 8, 16, 24 or 32");
   end
   if (PC_WIDTH < 1 || PC_WIDTH > 32) begin : g_bad_pc
      $error("PC_WIDTH must lie between 1 and 32");
   end
   if (`PCH_NO_LEVEL < NUM_LEVELS) begin : g_bad_none
      $error("The no-level code must lie above every chain index");
   end

   typedef struct packed {
      logic [N-1:0] sync1;
      logic [N-1:0] sync2;
      logic [N-1:0] prev;
      logic [N-1:0] pending;
      logic [N-1:0] mask;
      logic [N-1:0] active;
      prio_chain_pkg::indicator_s flags;
      logic wb_ack;
      logic [31:0] wb_dat;
      logic entry_req;
      logic [5:0] entry_level;
      logic restore_valid;
      logic [PC_WIDTH-1:0] restore_pc;
      logic irq;
   } chain_s;

   chain_s r;
   chain_s next_r;

   // Save stack; one entry per active level, so it cannot overflow
   logic push;
   logic pop;
   logic [SW-1:0] push_data;
   logic [SW-1:0] top_data;
   logic [DW-1:0] depth;

   save_stack #(
      .DEPTH(N),
      .WIDTH(SW)
   ) u_save_stack (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .clk_en_in(clk_en_in),
      .push_in(push),
      .pop_in(pop),
      .push_data_in(push_data),
      .top_data_out(top_data),
      .depth_out(depth)
   );

   // Lowest set index, or no-level when empty
   function automatic logic [5:0] lowest_set(input logic [N-1:0] v);
      logic [5:0] idx;
      idx = `PCH_NO_LEVEL;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 6'(i);
         end
      end
      return idx;
   endfunction

   // One-hot vector of a chain index, empty for no-level
   function automatic logic [N-1:0] onehot(input logic [5:0] idx);
      logic [N-1:0] v;
      v = '0;
      for (int i = 0; i < N; i++) begin
         if (idx == 6'(i)) begin
            v[i] = 1'b1;
         end
      end
      return v;
   endfunction

   // Offered level number, zero when nothing outranks current service
   function automatic logic [5:0] offer(input logic [N-1:0] pend,
                                        input logic [N-1:0] msk,
                                        input logic [N-1:0] act);
      logic [5:0] cand;
      logic [5:0] cur;
      cand = lowest_set(pend & msk);  // [RQ10] [RQ1]
      cur = lowest_set(act);
      return (cand < cur) ? cand + 6'h01 : 6'h00;  // [RQ7] [RQ11]
   endfunction

   // Read image of a register; unmapped and write-only words read zero
   function automatic logic [31:0] read_word(input prio_chain_pkg::reg_sel_e s,
                                             input logic [N-1:0] pend,
                                             input logic [N-1:0] msk,
                                             input logic [N-1:0] act,
                                             input logic [DW-1:0] dep,
                                             input prio_chain_pkg::indicator_s flg);
      logic [31:0] w;
      w = '0;
      case (s)
         prio_chain_pkg::SEL_STATUS: w = 32'(pend);
         prio_chain_pkg::SEL_MASK: w = 32'(msk);
         prio_chain_pkg::SEL_ACTIVE: w = 32'(act);
         prio_chain_pkg::SEL_SERVICE: begin
            w[`PCH_SVC_LEVEL_LSB +: 6] = lowest_set(act);
            w[`PCH_SVC_DEPTH_LSB +: DW] = dep;
         end
         prio_chain_pkg::SEL_FLAGS: w = 32'(flg);
         default: w = '0;
      endcase
      return w;
   endfunction

   // Byte-lane merge of a write into a register image
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic prio_chain_pkg::reg_sel_e decode(input logic [7:0] adr);
      prio_chain_pkg::reg_sel_e s;
      case (adr)
         `PCH_OFS_STATUS: s = prio_chain_pkg::SEL_STATUS;
         `PCH_OFS_MASK: s = prio_chain_pkg::SEL_MASK;
         `PCH_OFS_ACTIVE: s = prio_chain_pkg::SEL_ACTIVE;
         `PCH_OFS_PROGREQ: s = prio_chain_pkg::SEL_PROGREQ;
         `PCH_OFS_SERVICE: s = prio_chain_pkg::SEL_SERVICE;
         `PCH_OFS_FLAGS: s = prio_chain_pkg::SEL_FLAGS;
         default: s = prio_chain_pkg::SEL_NONE;
      endcase
      return s;
   endfunction

   logic [N-1:0] raw_req;
   logic [N-1:0] rise;
   logic [N-1:0] set_req;
   logic [N-1:0] clr_req;
   logic [N-1:0] onehot_entry;
   logic [N-1:0] onehot_done;
   logic [5:0] entry_idx;
   logic [5:0] cur_idx;
   logic take_entry;
   logic take_done;
   logic bus_req;
   logic [31:0] merged;
   prio_chain_pkg::reg_sel_e sel;

   // Internal sources on the top four levels, customer lines below
   always_comb begin
      raw_req = '0;
      raw_req[`PCH_IDX_POWER] = power_fail_in;  // [RQ4] [RQ9]
      raw_req[`PCH_IDX_TELETYPE] = teletype_req_in;  // [RQ4]
      raw_req[`PCH_IDX_BUTTON] = panel_button_in;  // [RQ4]
      raw_req[N-1:`PCH_INTERNAL_LEVELS] = customer_req_in;  // [RQ3]
   end

   assign push_data = {pc_in, r.flags};
   assign push = take_entry;
   assign pop = take_done;

   always_comb begin
      next_r = r;
      set_req = '0;
      clr_req = '0;
      onehot_entry = '0;
      onehot_done = '0;
      merged = '0;
      bus_req = wb_cyc_in && wb_stb_in && !r.wb_ack;
      sel = decode(wb_adr_in);

      // Two-flop synchronisers, edge taken from the second stage
      // A pin already high at reset release counts as a fresh edge
      next_r.sync1 = raw_req;
      next_r.sync2 = r.sync1;
      next_r.prev = r.sync2;
      rise = r.sync2 & ~r.prev;
      // Program level has no pin
      rise[`PCH_IDX_PROGRAM] = 1'b0;
      set_req = rise;

      // Bus slave: one access answered per request, ack for one cycle
      next_r.wb_ack = bus_req;
      next_r.wb_dat = '0;
      if (bus_req && wb_we_in) begin
         case (sel)
            prio_chain_pkg::SEL_STATUS: begin
               merged = lane_merge('0, wb_dat_in, wb_sel_in);
               clr_req = merged[N-1:0];
            end
            prio_chain_pkg::SEL_MASK: begin
               merged = lane_merge(32'(r.mask), wb_dat_in, wb_sel_in);
               next_r.mask = merged[N-1:0];
            end
            prio_chain_pkg::SEL_PROGREQ: begin
               if (wb_sel_in[0] && wb_dat_in[0]) begin
                  set_req[`PCH_IDX_PROGRAM] = 1'b1;  // [RQ4]
               end
            end
            default: begin
               merged = '0;
            end
         endcase
      end else if (bus_req) begin
         next_r.wb_dat = read_word(sel, r.pending, r.mask, r.active, depth, r.flags);
      end

      // Entry is taken only for the level on offer
      take_entry = entry_ack_in && r.entry_req;
      take_done = service_done_in && (r.active != '0);
      entry_idx = r.entry_level - 6'h01;
      cur_idx = lowest_set(r.active);
      if (take_entry) begin
         onehot_entry = onehot(entry_idx);
         clr_req = clr_req | onehot_entry;
      end
      if (take_done) begin
         // Innermost routine is always the highest active level
         onehot_done = onehot(cur_idx);  // [RQ5]
      end
      next_r.active = (r.active & ~onehot_done) | onehot_entry;  // [RQ5]

      // New requests win over a clear in the same cycle
      next_r.pending = (r.pending & ~clr_req) | set_req;  // [RQ11]

      // Indicators: restore on return, else arithmetic update
      next_r.restore_valid = take_done;
      if (take_done) begin
         next_r.flags = top_data[3:0];  // [RQ6]
         next_r.restore_pc = top_data[SW-1:4];  // [RQ6] [RQ9]
      end else if (alu_update_in) begin
         next_r.flags.zero_result_flag = zero_result_flag_in;  // [RQ8]
         next_r.flags.positive_result_flag = positive_result_flag_in;  // [RQ8]
         next_r.flags.negative_result_flag = negative_result_flag_in;  // [RQ8]
         next_r.flags.overflow_result_flag = overflow_result_flag_in;  // [RQ8]
      end

      // Grant: best unmasked pending level strictly above current service
      // Equal levels never offer, so a repeat waits for its own return
      next_r.entry_level = offer(next_r.pending, next_r.mask, next_r.active);
      next_r.entry_req = (next_r.entry_level != 6'h00);  // [RQ7] [RQ11]
      next_r.irq = |(next_r.pending & next_r.mask);
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         r <= '0;
         r.mask <= N'(`PCH_MASK_RESET);
         r.pending <= N'(`PCH_STATUS_RESET);
         r.flags <= `PCH_FLAGS_RESET;
      end else if (clk_en_in) begin
         r <= next_r;
      end
   end

   assign wb_ack_out = r.wb_ack;
   assign wb_dat_out = r.wb_dat;
   assign entry_req_out = r.entry_req;
   assign entry_level_out = r.entry_level;
   assign restore_valid_out = r.restore_valid;
   assign restore_pc_out = r.restore_pc;
   assign irq_out = r.irq;
   assign zero_result_flag_out = r.flags.zero_result_flag;
   assign positive_result_flag_out = r.flags.positive_result_flag;
   assign negative_result_flag_out = r.flags.negative_result_flag;
   assign overflow_result_flag_out = r.flags.overflow_result_flag;

endmodule

// ### dv/chain_props.sv
// Checker of the chain's bus, grant and restore timing.
// Sees only the chain's ports; bound at the foot.
`timescale 1ns/1ps
module chain_props #(
   parameter int NUM_LEVELS = 8
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic wb_ack_out,
   input wire logic power_fail_in,
   input wire logic entry_ack_in,
   input wire logic service_done_in,
   input wire logic entry_req_out,
   input wire logic [5:0] entry_level_out,
   input wire logic restore_valid_out,
   input wire logic irq_out
);
   logic mask0;
   logic [5:0] depth;
   wire logic take = wb_cyc_in && wb_stb_in && !wb_ack_out;
   wire logic enter = entry_req_out && entry_ack_in;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // Mirror of level one mask bit and of nesting depth
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         mask0 <= 1'b0;
         depth <= 6'h00;
      end else begin
         if (take && wb_we_in && wb_adr_in == 8'h04 && wb_sel_in[0]) begin
            mask0 <= wb_dat_in[0];
         end
         if (enter && !service_done_in) begin
            depth <= depth + 6'h01;
         end else if (!enter && service_done_in && depth != 6'h00) begin
            depth <= depth - 6'h01;
         end
      end
   end
   a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack too long");
   a_ack_next: assert property (take |=> wb_ack_out)
      else $error("no ack");
   a_offer_range: assert property (entry_req_out |->
      entry_level_out >= 6'h01 && entry_level_out <= NUM_LEVELS) else $error("bad level");
   a_offer_idle: assert property (!entry_req_out |-> entry_level_out == 6'h00)
      else $error("level without offer");
   a_preempt_only: assert property (enter && !service_done_in |=>
      !entry_req_out || entry_level_out < $past(entry_level_out)) else $error("no preempt");
   a_power_grant: assert property ($rose(power_fail_in) && mask0 |->
      ##[3:5] (entry_req_out && entry_level_out == 6'h01)) else $error("power not offered");
   a_power_irq: assert property ($rose(power_fail_in) && mask0 |-> ##[3:5] irq_out)
      else $error("power no irq");
   a_restore_due: assert property (service_done_in && !enter && depth != 6'h00
      |=> restore_valid_out) else $error("no restore");
   a_restore_cause: assert property (restore_valid_out |->
      $past(service_done_in) && $past(depth) != 6'h00) else $error("stray restore");
   a_restore_pulse: assert property (restore_valid_out |=> !restore_valid_out)
      else $error("restore too long");
   c_nested: cover property (depth == 6'h04);
   c_restore: cover property (restore_valid_out);
   c_power: cover property (entry_req_out && entry_level_out == 6'h01);
endmodule

bind priority_interrupt_chain chain_props #(.NUM_LEVELS(NUM_LEVELS)) u_chain_props (.*);

// ### dv/request_sources.sv
// Request sources: each fired line rises and holds for hold_in cycles.
// Assumes fire pulses come on the same clock.
`timescale 1ns/1ps
module request_sources #(
   parameter int N = 8
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic [N-1:0] fire_in,
   input wire logic [3:0] hold_in,
   output logic [N-1:0] pin_out
);
   logic [3:0] cnt [N];
   always_ff @(posedge mclk_in) begin
      for (int i = 0; i < N; i++) begin
         if (rst_in) begin
            cnt[i] <= 4'h0;
         end else begin
            cnt[i] <= fire_in[i] ? hold_in : cnt[i] - {3'h0, cnt[i] != 4'h0};
         end
      end
   end
   always_comb begin
      for (int i = 0; i < N; i++) begin
         pin_out[i] = cnt[i] != 4'h0;
      end
   end
endmodule

// ### dv/priority_interrupt_chain_test.sv
// Bench of the chain: registers, order, nesting, save and restore.
// Assumes request_sources drives the pins and chain_props is bound.
`timescale 1ns/1ps
module priority_interrupt_chain_test;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, alu = 1'b0, eack = 1'b0, done = 1'b0;
   logic [7:0] adr = 8'h00, fire = 8'h00;
   logic [3:0] sel = 4'hf, fin = 4'h0, hold = 4'h1, cur_f = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [15:0] pc = 16'h0;
   wire ack, ereq, rv, irq;
   wire [3:0] fout;
   wire [5:0] lvl;
   wire [7:0] pin;
   wire [15:0] rpc;
   wire [31:0] rdat;
   int bad_count = 0, comparisons = 0, cycles = 0;
   logic [31:0] rd_q[$];
   logic [5:0] lv_q[$];
   logic [19:0] rs_q[$], stk[$];

   always #2.5 mclk_in = ~mclk_in;
   request_sources #(.N(8)) u_request_sources (.mclk_in(mclk_in), .rst_in(rst_in),
      .fire_in(fire), .hold_in(hold), .pin_out(pin));
   priority_interrupt_chain u_priority_interrupt_chain (.mclk_in(mclk_in), .rst_in(rst_in),
      .clk_en_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .power_fail_in(pin[0]), .teletype_req_in(pin[2]), .panel_button_in(pin[3]),
      .customer_req_in(pin[7:4]), .alu_update_in(alu),
      .zero_result_flag_in(fin[0]), .positive_result_flag_in(fin[1]),
      .negative_result_flag_in(fin[2]), .overflow_result_flag_in(fin[3]),
      .zero_result_flag_out(fout[0]), .positive_result_flag_out(fout[1]),
      .negative_result_flag_out(fout[2]), .overflow_result_flag_out(fout[3]),
      .pc_in(pc), .entry_ack_in(eack), .service_done_in(done), .entry_req_out(ereq),
      .entry_level_out(lvl), .restore_valid_out(rv), .restore_pc_out(rpc), .irq_out(irq));

   task chk(input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t exp %h got %h", $time, e, g);
      end
   endtask
   task chk_rd(input logic [31:0] e, input logic [31:0] g);
      chk(e, g);
   endtask
   task chk_lvl(input logic [5:0] e, input logic [5:0] g);
      chk({26'h0, e}, {26'h0, g});
   endtask
   task chk_rs(input logic [19:0] e, input logic [19:0] g);
      chk({12'h0, e}, {12'h0, g});
   endtask
   task chk_bit(input logic e, input logic g);
      chk({31'h0, e}, {31'h0, g});
   endtask
   task summarize;
      if (bad_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge mclk_in); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task fire_lvl(input int l);
      @(posedge mclk_in);
      fire[l-1] <= 1'b1;
      hold <= 4'($urandom_range(15, 1));
      @(posedge mclk_in);
      fire <= 8'h00;
   endtask
   task enter(input logic [5:0] l);
      logic [15:0] p;
      p = 16'($urandom);
      lv_q.push_back(l);
      stk.push_back({cur_f, p});
      do @(posedge mclk_in); while (ereq !== 1'b1);
      eack <= 1'b1;
      pc <= p;
      @(posedge mclk_in);
      eack <= 1'b0;
      repeat (2) @(posedge mclk_in);
   endtask
   task leave;
      logic [19:0] s;
      s = stk.pop_back();
      rs_q.push_back(s);
      cur_f = s[19:16];
      done <= 1'b1;
      @(posedge mclk_in);
      done <= 1'b0;
      repeat (2) @(posedge mclk_in);
   endtask
   task alu_set;
      logic [3:0] f;
      f = 4'($urandom);
      fin <= f;
      alu <= 1'b1;
      @(posedge mclk_in);
      alu <= 1'b0;
      cur_f = f;
      rd(8'h14, {28'h0, f});
   endtask

   // Results against the oldest note of each kind
   always @(posedge mclk_in) begin
      if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) begin
         chk_rd(rd_q.pop_front(), rdat);
      end
      if (ereq === 1'b1 && eack === 1'b1 && lv_q.size() > 0) begin
         chk_lvl(lv_q.pop_front(), lvl);
      end
      if (rv === 1'b1 && rs_q.size() > 0) begin
         chk_rs(rs_q.pop_front(), {fout, rpc});
      end
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize;
      end
   end

   initial begin
      void'($urandom(32'h4164));
      repeat (6) @(posedge mclk_in);
      rst_in <= 1'b0;
      wb(1'b1, 8'h18, $urandom);
      for (int i = 0; i < 7; i++) rd(8'(i * 4), i == 4 ? 32'h20 : 32'h0);
      fire_lvl(3);
      repeat (8) @(posedge mclk_in);
      chk_bit(1'b0, irq);
      rd(8'h00, 32'h4);
      wb(1'b1, 8'h00, 32'h4);
      rd(8'h00, 32'h0);
      wb(1'b1, 8'h04, 32'hff);
      rd(8'h04, 32'hff);
      for (int i = 3; i <= 8; i++) fire_lvl(i);
      for (int i = 3; i <= 8; i++) begin
         enter(6'(i));
         alu_set;
         leave;
      end
      fire_lvl(8);
      enter(6'h08);
      alu_set;
      fire_lvl(5);
      enter(6'h05);
      alu_set;
      fire_lvl(5);
      wb(1'b1, 8'h0c, 32'h1);
      enter(6'h02);
      alu_set;
      fire_lvl(1);
      enter(6'h01);
      fire_lvl(3);
      repeat (8) @(posedge mclk_in);
      chk_bit(1'b0, ereq);
      chk_bit(1'b1, irq);
      rd(8'h08, 32'h93);
      rd(8'h10, 32'h400);
      leave;
      leave;
      enter(6'h03);
      leave;
      leave;
      enter(6'h05);
      leave;
      leave;
      rd(8'h10, 32'h20);
      @(posedge mclk_in);
      if (rd_q.size() + lv_q.size() + rs_q.size() != 0) begin
         bad_count++;
      end
      summarize;
   end
endmodule
